// ### dv/nvac_fw.sv
`timescale 1ns/1ps
module nvac_fw (
	// Clock
	input wire logic clock_in,
	// Bus answer
	input wire logic ack_in,
	input wire logic [31:0] dat_in,
	// Bus request
	output logic cyc_out,
	output logic stb_out,
	output logic we_out,
	output logic [3:0] adr_out,
	output logic [3:0] sel_out,
	output logic [31:0] dat_out
);
	// Idle bus at time zero
	initial begin
		cyc_out = 1'b0;
		stb_out = 1'b0;
		we_out = 1'b0;
		adr_out = 4'h0;
		sel_out = 4'h0;
		dat_out = 32'h0000_0000;
	end
	////////////////////////////////////////////////////////////////
	// One classic cycle, held until ack is sampled high
	task automatic xfer(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clock_in);
		cyc_out <= 1'b1;
		stb_out <= 1'b1;
		we_out <= we;
		adr_out <= a;
		sel_out <= s;
		dat_out <= d;
		// Wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge clock_in);
		end while (ack_in !== 1'b1);
		// Read data taken at the ack edge
		q = dat_in;
		cyc_out <= 1'b0;
		stb_out <= 1'b0;
		// Released address and data lines show the inverse, not the last value
		adr_out <= ~a;
		dat_out <= ~d;
	endtask
endmodule

// ### dv/nvac_top_bench.sv
`timescale 1ns/1ps
module nvac_top_bench;
	import nvac_pkg::*;
	localparam int WC = 20;
	typedef struct packed {logic [3:0] adr; logic [31:0] wd; logic [31:0] rd;} nvac_row_t;
	logic clock_in, rstn_in, abort_rst, cyc, stb, we, ack, busy, done, cfg;
	logic [3:0] adr, sel;
	logic [31:0] wd, rd, q;
	int err_count, checks, n, busy_cycles;
	nvac_row_t rows [4] = '{'{4'h8, 32'h0000_00A5, 32'h0000_00A5}, '{4'hC, 32'h0000_003C, 32'h0000_003C},
		'{4'h4, 32'h0000_0055, 32'h0000_0000}, '{4'h2, 32'h0000_00FF, 32'h0000_0000}};
	// Refused start attempts: prior control, two keys, start write
	logic [7:0] bad [4][4] = '{'{8'h04, 8'hAA, 8'h55, 8'h06}, '{8'h00, 8'h55, 8'hAA, 8'h06},
		'{8'h00, 8'h55, 8'hAA, 8'h02}, '{8'h04, 8'h55, 8'h56, 8'h06}};
	nvac_top #(.WRITE_CYC(WC)) DUT (.clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack),
		.write_abort_rst_in(abort_rst), .write_busy_out(busy), .nv_done_flag_out(done), .cfg_target_out(cfg));
	nvac_fw FW (.clock_in(clock_in), .ack_in(ack), .dat_in(rd), .cyc_out(cyc), .stb_out(stb), .we_out(we),
		.adr_out(adr), .sel_out(sel), .dat_out(wd));
	// Clock, 10 ns period
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	// Counts edges with the write start bit high
	always @(posedge clock_in) begin
		if (busy === 1'b1) busy_cycles <= busy_cycles + 1;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	// Lane 0 write, leaves the done flag alone
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		FW.xfer(1'b1, a, 4'h1, {24'h00_0000, d}, q);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string m);
		FW.xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
		check(q, e, m);
	endtask
	task automatic reset();
		rstn_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		rstn_in <= 1'b1;
	endtask
	task automatic give_verdict();
		$display("Counts: %0d checks, %0d mismatches", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog far beyond the expected run
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		rstn_in = 1'b0;
		abort_rst = 1'b0;
		err_count = 0;
		checks = 0;
		busy_cycles = 0;
		reset();
		rdc(NVAC_OFS_CTRL, 32'h0000_0000, "ctrl reset");
		rdc(NVAC_OFS_DATA, 32'h0000_0000, "data reset");
		rdc(NVAC_OFS_ADDR, 32'h0000_0000, "addr reset");
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].adr, rows[i].wd[7:0]);
			rdc(rows[i].adr, rows[i].rd, "readback");
		end
		$display("register table done");
		// Unlocked byte write, then locked-out register writes
		wr(NVAC_OFS_ADDR, 8'h5A);
		wr(NVAC_OFS_DATA, 8'hC3);
		wr(NVAC_OFS_CTRL, 8'h04);
		wr(NVAC_OFS_KEY, NVAC_KEY1);
		wr(NVAC_OFS_KEY, NVAC_KEY2);
		wr(NVAC_OFS_CTRL, 8'h06);
		check(busy, 1'b1, "write started");
		wr(NVAC_OFS_DATA, 8'h11);
		wr(NVAC_OFS_ADDR, 8'h77);
		wr(NVAC_OFS_CTRL, 8'h00);
		n = 0;
		while (busy === 1'b1 && n < WC + 10) begin
			@(posedge clock_in);
			n++;
		end
		check(busy, 1'b0, "write ended");
		check(busy_cycles, WC, "write length");
		check(done, 1'b1, "done set");
		rdc(NVAC_OFS_CTRL, 32'h0000_0104, "enable kept, done");
		rdc(NVAC_OFS_ADDR, 32'h0000_005A, "addr locked");
		rdc(NVAC_OFS_DATA, 32'h0000_00C3, "data locked");
		wr(NVAC_OFS_DATA, 8'h00);
		wr(NVAC_OFS_CTRL, 8'h05);
		rdc(NVAC_OFS_DATA, 32'h0000_00C3, "array byte");
		check(done, 1'b1, "done held");
		FW.xfer(1'b1, NVAC_OFS_CTRL, 4'h2, 32'h0000_0000, q);
		check(done, 1'b0, "done cleared");
		$display("byte write test done");
		// Refused write starts
		foreach (bad[i]) begin
			wr(NVAC_OFS_CTRL, bad[i][0]);
			wr(NVAC_OFS_KEY, bad[i][1]);
			wr(NVAC_OFS_KEY, bad[i][2]);
			wr(NVAC_OFS_CTRL, bad[i][3]);
			check(busy, 1'b0, "start refused");
		end
		$display("refusal test done");
		// Flash select blocks the read start
		wr(NVAC_OFS_CTRL, 8'h81);
		rdc(NVAC_OFS_CTRL, 32'h0000_0080, "read start blocked");
		rdc(NVAC_OFS_DATA, 32'h0000_00C3, "data untouched");
		wr(NVAC_OFS_CTRL, 8'h40);
		check(cfg, 1'b1, "config target");
		$display("select test done");
		// Reset that cut off a write
		abort_rst <= 1'b1;
		reset();
		@(posedge clock_in);
		abort_rst <= 1'b0;
		rdc(NVAC_OFS_CTRL, 32'h0000_0008, "interrupted flag");
		rdc(NVAC_OFS_ADDR, 32'h0000_0000, "addr cleared");
		$display("abort test done");
		give_verdict();
	end
endmodule

// ### rtl/nvac_pkg.sv
package nvac_pkg;
	// Register byte offsets on the bus
	localparam logic [3:0] NVAC_OFS_CTRL = 4'h0;
	localparam logic [3:0] NVAC_OFS_KEY = 4'h4;
	localparam logic [3:0] NVAC_OFS_DATA = 4'h8;
	localparam logic [3:0] NVAC_OFS_ADDR = 4'hC;
	// Control register fields
	localparam int NVAC_B_FLASH = 7;
	localparam int NVAC_B_CFG = 6;
	localparam int NVAC_B_FREE = 4;
	localparam int NVAC_B_ERR = 3;
	localparam int NVAC_B_ERASE_PROGRAM_ENABLE = 2;
	localparam int NVAC_B_WR = 1;
	localparam int NVAC_B_RD = 0;
	// Status register field, done flag
	localparam int NVAC_B_DONE = 8;
	// Unlock keys
	localparam logic [7:0] NVAC_KEY1 = 8'h55;
	localparam logic [7:0] NVAC_KEY2 = 8'hAA;
	// Reset values
	localparam logic [7:0] NVAC_DATA_RST = 8'h00;
	localparam logic [7:0] NVAC_ADDR_RST = 8'h00;
	// Write time per byte, erase half and program half
	localparam int NVAC_WRITE_NS = 4000000;
	localparam int NVAC_CLK_NS = 10;
	localparam int NVAC_WRITE_CYC = NVAC_WRITE_NS / NVAC_CLK_NS;
	// Key tracker states
	typedef enum logic [2:0] {
		NVAC_K_IDLE = 3'b001,
		NVAC_K_ONE = 3'b010,
		NVAC_K_TWO = 3'b100
	} nvac_key_t;
	// Write engine states
	typedef enum logic [2:0] {
		NVAC_W_IDLE = 3'b001,
		NVAC_W_ERASE = 3'b010,
		NVAC_W_PROG = 3'b100
	} nvac_wst_t;
endpackage

// ### rtl/nvac_top.sv
`timescale 1ns/1ps
module nvac_top #(
	parameter int WRITE_CYC = nvac_pkg::NVAC_WRITE_CYC,
	parameter int DEPTH = 256
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Reset cause from the system: a reset that cut off a write
	input wire logic write_abort_rst_in,
	// Status levels
	output logic write_busy_out,
	output logic nv_done_flag_out,
	output logic cfg_target_out
);
	import nvac_pkg::*;

	// Refuse sizes the logic cannot serve
	if (WRITE_CYC < 2 || DEPTH != 256) begin : g_bad_param
		$error("nvac_top: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic acc, wr_acc, lane0, lane1;
	logic ctrl_wr, key_wr, data_wr, addr_wr, stat_wr;
	logic [7:0] wbyte;
	assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_acc = acc && wb_we_in;
	assign lane0 = wb_sel_in[0];
	assign lane1 = wb_sel_in[1];
	assign wbyte = wb_dat_in[7:0];
	assign ctrl_wr = wr_acc && lane0 && wb_adr_in == NVAC_OFS_CTRL;
	assign stat_wr = wr_acc && lane1 && wb_adr_in == NVAC_OFS_CTRL;
	assign key_wr = wr_acc && lane0 && wb_adr_in == NVAC_OFS_KEY;
	assign data_wr = wr_acc && lane0 && wb_adr_in == NVAC_OFS_DATA;
	assign addr_wr = wr_acc && lane0 && wb_adr_in == NVAC_OFS_ADDR;

	// Ack one cycle after the request, dropped the next
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= acc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic flash_select_reg, config_space_select_reg, free_reg;
	logic erase_program_enable_reg, interrupted_program_flag_reg;
	logic wr_bit_reg, nv_done_flag_reg;
	logic [7:0] nv_data_reg, nv_address_reg;
	logic [7:0] mem [DEPTH];
	nvac_key_t key_reg, key_next;
	nvac_wst_t wst_reg;
	logic [31:0] tmr_reg;
	logic busy, start_ok, rd_ok, timer_done;

	assign busy = wst_reg != NVAC_W_IDLE;
	assign timer_done = tmr_reg == 32'h0000_0000;
	// Start needs keys done, enable already set, and data array selected
	assign start_ok = ctrl_wr && wbyte[NVAC_B_WR] && !busy && key_reg == NVAC_K_TWO
		&& erase_program_enable_reg
		&& !flash_select_reg && !config_space_select_reg;
	assign rd_ok = ctrl_wr && wbyte[NVAC_B_RD] && !busy && !wbyte[NVAC_B_FLASH]
		&& !wbyte[NVAC_B_CFG];

	// Key sequence tracker
	always_comb begin
		key_next = NVAC_K_IDLE;
		if (key_wr && !busy) begin
			unique case (key_reg)
				NVAC_K_IDLE: key_next = (wbyte == NVAC_KEY1) ? NVAC_K_ONE : NVAC_K_IDLE;
				NVAC_K_ONE: key_next = (wbyte == NVAC_KEY2) ? NVAC_K_TWO : NVAC_K_IDLE;
				NVAC_K_TWO: key_next = NVAC_K_IDLE;
				default: key_next = NVAC_K_IDLE;
			endcase
		end else if (!ctrl_wr && !key_wr) begin
			key_next = key_reg;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			key_reg <= NVAC_K_IDLE;
		end else begin
			key_reg <= key_next;
		end
	end

	// Control bits, frozen while a write runs
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flash_select_reg <= 1'b0;
			config_space_select_reg <= 1'b0;
			free_reg <= 1'b0;
			erase_program_enable_reg <= 1'b0;
		end else if (ctrl_wr && !busy) begin
			flash_select_reg <= wbyte[NVAC_B_FLASH];
			config_space_select_reg <= wbyte[NVAC_B_CFG];
			free_reg <= wbyte[NVAC_B_FREE];
			erase_program_enable_reg <= wbyte[NVAC_B_ERASE_PROGRAM_ENABLE];
		end
	end

	// Interrupted write flag; caught on the first clock after reset
	logic abort_seen_reg;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			abort_seen_reg <= 1'b0;
			interrupted_program_flag_reg <= 1'b0;
		end else begin
			abort_seen_reg <= 1'b1;
			if (!abort_seen_reg && write_abort_rst_in) begin
				interrupted_program_flag_reg <= 1'b1;
			end else if (ctrl_wr && !busy) begin
				interrupted_program_flag_reg <= wbyte[NVAC_B_ERR];
			end
		end
	end

	// Done flag, set wins over clear
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nv_done_flag_reg <= 1'b0;
		end else if (busy && wst_reg == NVAC_W_PROG && timer_done) begin
			nv_done_flag_reg <= 1'b1;
		end else if (stat_wr && !wb_dat_in[NVAC_B_DONE]) begin
			nv_done_flag_reg <= 1'b0;
		end
	end

	// Address register
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nv_address_reg <= NVAC_ADDR_RST;
		end else if (addr_wr && !busy) begin
			nv_address_reg <= wbyte;
		end
	end

	// Data register: read result or firmware write
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nv_data_reg <= NVAC_DATA_RST;
		end else if (rd_ok) begin
			nv_data_reg <= mem[nv_address_reg];
		end else if (data_wr && !busy) begin
			nv_data_reg <= wbyte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write engine: erase then program, timed
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wst_reg <= NVAC_W_IDLE;
			tmr_reg <= 32'h0000_0000;
			wr_bit_reg <= 1'b0;
		end else begin
			unique case (wst_reg)
				NVAC_W_IDLE: begin
					if (start_ok) begin
						wst_reg <= NVAC_W_ERASE;
						tmr_reg <= 32'(WRITE_CYC / 2 - 1);
						wr_bit_reg <= 1'b1;
					end
				end
				NVAC_W_ERASE: begin
					if (timer_done) begin
						wst_reg <= NVAC_W_PROG;
						tmr_reg <= 32'(WRITE_CYC - WRITE_CYC / 2 - 1);
					end else begin
						tmr_reg <= tmr_reg - 32'h0000_0001;
					end
				end
				NVAC_W_PROG: begin
					if (timer_done) begin
						wst_reg <= NVAC_W_IDLE;
						wr_bit_reg <= 1'b0;
					end else begin
						tmr_reg <= tmr_reg - 32'h0000_0001;
					end
				end
			endcase
		end
	end

	// Array: erased at end of erase, programmed at end
	always_ff @(posedge clock_in) begin
		if (rstn_in && wst_reg == NVAC_W_ERASE && timer_done) begin
			mem[nv_address_reg] <= 8'hFF;
		end else if (rstn_in && wst_reg == NVAC_W_PROG && timer_done) begin
			mem[nv_address_reg] <= nv_data_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, registered; key port reads zero
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_dat_out <= 32'h0000_0000;
		end else if (acc && !wb_we_in) begin
			unique case (wb_adr_in)
				NVAC_OFS_CTRL: wb_dat_out <= {23'h00_0000, nv_done_flag_reg, flash_select_reg,
					config_space_select_reg, 1'b0, free_reg, interrupted_program_flag_reg,
					erase_program_enable_reg, wr_bit_reg, 1'b0};
				NVAC_OFS_DATA: wb_dat_out <= {24'h00_0000, nv_data_reg};
				NVAC_OFS_ADDR: wb_dat_out <= {24'h00_0000, nv_address_reg};
				default: wb_dat_out <= 32'h0000_0000;
			endcase
		end
	end

	assign write_busy_out = wr_bit_reg;
	assign nv_done_flag_out = nv_done_flag_reg;
	assign cfg_target_out = config_space_select_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Cycles with the write start bit high, for the length check
	logic [31:0] len_cnt_reg;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			len_cnt_reg <= 32'h0000_0000;
		end else if (wr_bit_reg) begin
			len_cnt_reg <= len_cnt_reg + 32'h0000_0001;
		end else begin
			len_cnt_reg <= 32'h0000_0000;
		end
	end

	// Enable and start in one write never start
	same_write_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(ctrl_wr && !erase_program_enable_reg) |=> !wr_bit_reg || $past(busy))
		else $error("write started without prior enable");
	// Address frozen during a write
	lock_addr_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		($past(busy) && busy) |-> $stable(nv_address_reg))
		else $error("address changed during write");
	// Start needs both keys
	key_need_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(wr_bit_reg) |-> $past(key_reg) == NVAC_K_TWO)
		else $error("write started without keys");
	// Done set at write end
	done_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$fell(wr_bit_reg) |-> nv_done_flag_reg)
		else $error("done flag not set at write end");
	// Only firmware clears done
	done_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		($fell(nv_done_flag_reg)) |-> $past(stat_wr))
		else $error("done flag cleared by hardware");
	// Only firmware clears enable
	erase_program_enable_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$fell(erase_program_enable_reg) |-> $past(ctrl_wr))
		else $error("enable cleared by hardware");
	// Read result stands the next cycle
	read_next_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		rd_ok |=> nv_data_reg == mem[$past(nv_address_reg)])
		else $error("read data not ready next cycle");
	// No read with flash selected
	flash_noread_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(ctrl_wr && wbyte[NVAC_B_FLASH]) |=> $stable(nv_data_reg) || $past(data_wr))
		else $error("read ran with flash selected");

	////////////////////////////////////////////////////////////////////////
	// Write engine, register and bus checks
	// Write length matches the count
	write_len_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$fell(wr_bit_reg) |-> len_cnt_reg == 32'(WRITE_CYC))
		else $error("write length differs from count");
	// Busy state holds the write start bit
	wr_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		wr_bit_reg == busy)
		else $error("write start bit and busy state differ");
	// Start blocked while enable is clear
	wr_refuse_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(ctrl_wr && wbyte[NVAC_B_WR] && !erase_program_enable_reg && !busy) |=> !wr_bit_reg)
		else $error("write started with enable clear");
	// Enable and select bits frozen during a write
	ctrl_lock_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		($past(busy) && busy) |-> $stable(erase_program_enable_reg) && $stable(flash_select_reg)
			&& $stable(config_space_select_reg))
		else $error("control changed during write");
	// Data register frozen during a write
	data_lock_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		($past(busy) && busy) |-> $stable(nv_data_reg))
		else $error("data changed during write");
	// Firmware write replaces the data byte
	data_load_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(data_wr && !busy) |=> nv_data_reg == $past(wbyte))
		else $error("data write lost");
	// Control writes clear the key tracker
	key_reset_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		ctrl_wr |=> key_reg == NVAC_K_IDLE)
		else $error("key tracker kept after control write");
	// Wrong key values clear the key tracker
	key_bad_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(key_wr && wbyte != NVAC_KEY1 && wbyte != NVAC_KEY2) |=> key_reg == NVAC_K_IDLE)
		else $error("key tracker kept after wrong key");
	// Start only with the data array selected
	start_sel_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(wr_bit_reg) |-> !$past(flash_select_reg) && !$past(config_space_select_reg))
		else $error("write started with other space selected");
	// Erase comes first
	erase_first_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(wr_bit_reg) |-> wst_reg == NVAC_W_ERASE)
		else $error("write did not open with erase");
	// Done rises only at write end
	done_rise_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(nv_done_flag_reg) |-> $fell(wr_bit_reg))
		else $error("done flag set outside write end");
	// Done holds without a firmware clear
	done_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(nv_done_flag_reg && !stat_wr) |=> nv_done_flag_reg)
		else $error("done flag dropped on its own");
	// Enable rises only by firmware
	erase_program_enable_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(erase_program_enable_reg) |-> $past(ctrl_wr))
		else $error("enable set by hardware");
	// Config select blocks the read
	cfg_noread_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		(ctrl_wr && wbyte[NVAC_B_CFG]) |=> $stable(nv_data_reg))
		else $error("read ran with config selected");
	// Cut write flag set after the reset
	err_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		($rose(abort_seen_reg) && $past(write_abort_rst_in)) |-> interrupted_program_flag_reg)
		else $error("interrupted flag not set");
	// Cut write flag cleared only by firmware
	err_keep_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$fell(interrupted_program_flag_reg) |-> $past(ctrl_wr))
		else $error("interrupted flag cleared by hardware");
	// Ack lasts one cycle
	ack_once_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
endmodule
